// File: rtl/supervisor_host_pkg.sv
// Package with constants and types for the clock supervisor host controller.
package supervisor_host_pkg;
	localparam int          CLK_PERIOD_PS      = 5000;
	localparam int          STAB_MARGIN_NUM    = 105;
	localparam int          STAB_MARGIN_DEN    = 100;
	localparam logic [2:0]  INTERVAL_SEL_RESET = 3'h2;
	localparam logic [1:0]  GEAR_DIV_NONE      = 2'h0;
	localparam logic [1:0]  GEAR_DIV_FOUR      = 2'h1;
	localparam logic [1:0]  GEAR_DIV_EIGHT     = 2'h2;
	localparam logic [1:0]  GEAR_DIV_SIXTEEN   = 2'h3;
	localparam logic [2:0]  INTERVAL_SHORTEST  = 3'h0;
	localparam logic [2:0]  INTERVAL_SECOND    = 3'h1;
	localparam logic [7:0]  COUNT_SATURATED    = 8'hFF;
	localparam logic [7:0]  COUNT_ZERO         = 8'h00;
	localparam logic [3:0]  VERDICT_NONE       = 4'h0;
	localparam int          POLL_LIMIT_DEFAULT = 1000000;
	localparam int          WAIT_CYCLES_DEFAULT = 8192;

	typedef enum logic [2:0] {
		ST_IDLE   = 3'b000,
		ST_WAIT   = 3'b001,
		ST_CHECK  = 3'b010,
		ST_START  = 3'b011,
		ST_POLL   = 3'b100,
		ST_READ   = 3'b101,
		ST_DONE   = 3'b110
	} host_state_type;

	typedef enum logic [1:0] {
		RES_NONE     = 2'b00,
		RES_NORMAL   = 2'b01,
		RES_ABNORMAL = 2'b10,
		RES_DEAD     = 2'b11
	} result_type;
endpackage

// File: rtl/level_sync.sv
// Two-flop synchroniser for a level arriving from outside the clock domain.
`timescale 1ns/1ps
module level_sync
	import supervisor_host_pkg::*;
#(
	parameter int WIDTH = 1
) (
	input  wire logic             core_clk,
	input  wire logic             rst_n,
	input  wire logic [WIDTH-1:0] asyncIn,
	output logic      [WIDTH-1:0] syncOut
);
	typedef struct packed {
		logic [WIDTH-1:0] first;
		logic [WIDTH-1:0] second;
	} sync_state_type;

	sync_state_type state_q;
	sync_state_type state_d;

	always_comb begin
		state_d        = state_q;
		state_d.first  = asyncIn;
		state_d.second = state_q.first;
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			state_q <= '0;
		end else begin
			state_q <= state_d;
		end
	end

	assign syncOut = state_q.second;
endmodule // level_sync

// File: rtl/supervisor_host.sv
// Host controller that runs one clock supervision check on the device.
// Contract
// [RULE1] Read result only after enable returns zero.
// [RULE2] Stopped time-base halts the device counter.
// [RULE3] Never clear time-base while counting runs; on poll timeout the host drops the inhibit while the enable is still high.
// [RULE4] Machine clock under half selected interval.
// [RULE5] Refuse prohibited gear and interval pairs.
// [RULE6] Late resumed clock delays enable clear.
// [RULE7] Enable clears on falling edge after window.
// [RULE8] Counter resets on that same falling edge.
// [RULE9] Expected count must avoid zero and 255.
// [RULE10] Interval long enough for meaningful count.
// [RULE11] Wait interval exceeds stabilization times 1.05.
// [RULE12] Use only in CR mode with watchdog.
// [RULE13] Check stable flag, write, poll, compare.
// [RULE14] Failed flag or mismatch stays CR mode.
// [RULE15] Device counts between two interval rising edges.
// [RULE16] Device counter saturates at 255.
// [RULE17] Device clears result on enable rise.
// [RULE18] Interval codes select 2^3..2^17 CR periods.
// [RULE19] Device counts rising edges of external clock.
`timescale 1ns/1ps
module supervisor_host
	import supervisor_host_pkg::*;
#(
	parameter int WAIT_CYCLES = WAIT_CYCLES_DEFAULT,
	parameter int POLL_LIMIT  = POLL_LIMIT_DEFAULT
) (
	input  wire logic       core_clk,
	input  wire logic       rst_n,
	input  wire logic       startReq,
	input  wire logic       sourceSub,
	input  wire logic [2:0] intervalSel,
	input  wire logic [1:0] gearDiv,
	input  wire logic       crModeActive,
	input  wire logic       watchdogStandby,
	input  wire logic [7:0] expectLow,
	input  wire logic [7:0] expectHigh,
	input  wire logic       mainOscStableFlag,
	input  wire logic       subOscStableFlag,
	input  wire logic       supervisorEnableIn,
	input  wire logic [7:0] measuredCountResult,
	output logic            supervisorEnableOut,
	output logic            sourceClockSelect,
	output logic [2:0]      intervalSelectOut,
	output logic            configWrite,
	output logic            timebaseClearInhibit,
	output logic            busy,
	output logic            done,
	output logic [1:0]      verdict,
	output logic [7:0]      countOut,
	output logic            requestRefused
);
	// The poll skips its first cycles while the synchroniser catches up.
	if (WAIT_CYCLES < 1 || POLL_LIMIT < 6) begin : gen_param_check
		$error("supervisor_host: wait count below one or poll limit below six");
	end

	typedef struct packed {
		host_state_type state;
		logic [31:0]    timer;
		logic           source;
		logic [2:0]     interval;
		logic [7:0]     low;
		logic [7:0]     high;
		logic           enableOut;
		logic           write;
		logic           inhibit;
		logic           busy;
		logic           done;
		logic [1:0]     verdict;
		logic [7:0]     count;
		logic           refused;
	} host_type;

	host_type state_q;
	host_type state_d;
	logic [3:0] syncIn;
	logic [7:0] syncCount;
	logic       mainStable;
	logic       subStable;
	logic       enableSeen;
	logic       pairAllowed;
	logic       stableSel;

	level_sync #(.WIDTH(4)) flagSync (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.asyncIn  ({mainOscStableFlag, subOscStableFlag, supervisorEnableIn, 1'b0}),
		.syncOut  (syncIn)
	);

	level_sync #(.WIDTH(8)) countSync (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.asyncIn  (measuredCountResult),
		.syncOut  (syncCount)
	);

	assign mainStable = syncIn[3];
	assign subStable  = syncIn[2];
	assign enableSeen = syncIn[1];
	assign stableSel  = state_q.source ? subStable : mainStable;

	// The refused pairs are those whose machine clock period reaches half the interval.
	always_comb begin
		pairAllowed = 1'b1;
		if (gearDiv == GEAR_DIV_SIXTEEN) begin
			pairAllowed = (intervalSel != INTERVAL_SHORTEST)
				&& (intervalSel != INTERVAL_SECOND); // [RULE4] [RULE5]
		end else if (gearDiv != GEAR_DIV_NONE) begin
			pairAllowed = (intervalSel != INTERVAL_SHORTEST); // [RULE4] [RULE5]
		end
	end

	always_comb begin
		state_d       = state_q;
		state_d.write = 1'b0;
		state_d.done  = 1'b0;
		case (state_q.state)
			ST_IDLE: begin
				if (startReq) begin
					// Supervision without CR mode and watchdog may hang the part.
					if (!pairAllowed || !crModeActive || !watchdogStandby) begin // [RULE12]
						state_d.refused = 1'b1;
					end else begin
						state_d.refused  = 1'b0;
						state_d.source   = sourceSub;
						state_d.interval = intervalSel;
						state_d.low      = expectLow;
						state_d.high     = expectHigh;
						state_d.busy     = 1'b1;
						state_d.verdict  = RES_NONE;
						state_d.timer    = 32'(WAIT_CYCLES);
						state_d.state    = ST_WAIT;
					end
				end
			end
			ST_WAIT: begin
				// The wait count is chosen by the user to cover the margin.
				if (state_q.timer <= 32'd1) begin // [RULE11]
					state_d.state = ST_CHECK;
				end else begin
					state_d.timer = state_q.timer - 32'd1;
				end
			end
			ST_CHECK: begin
				if (stableSel) begin // [RULE13]
					state_d.state = ST_START;
				end else begin
					state_d.verdict = RES_DEAD; // [RULE14]
					state_d.state   = ST_DONE;
				end
			end
			ST_START: begin
				state_d.enableOut = 1'b1; // [RULE13]
				state_d.write     = 1'b1;
				state_d.inhibit   = 1'b1; // [RULE3]
				state_d.timer     = 32'(POLL_LIMIT);
				state_d.state     = ST_POLL;
			end
			ST_POLL: begin
				state_d.enableOut = 1'b0;
				// The sampled enable lags by the synchroniser; skip the early cycles.
				if (state_q.timer < 32'(POLL_LIMIT) - 32'd4 && !enableSeen) begin // [RULE1]
					state_d.state = ST_READ;
				end else if (state_q.timer <= 32'd1) begin
					state_d.verdict = RES_DEAD;
					state_d.inhibit = 1'b0;
					state_d.state   = ST_DONE;
				end else begin
					state_d.timer = state_q.timer - 32'd1;
				end
			end
			ST_READ: begin
				state_d.inhibit = 1'b0;
				state_d.count   = syncCount; // [RULE1]
				if (syncCount >= state_q.low && syncCount <= state_q.high
					&& syncCount != COUNT_ZERO && syncCount != COUNT_SATURATED) begin // [RULE9] [RULE10]
					state_d.verdict = RES_NORMAL;
				end else begin
					state_d.verdict = RES_ABNORMAL; // [RULE14]
				end
				state_d.state = ST_DONE;
			end
			ST_DONE: begin
				state_d.busy  = 1'b0;
				state_d.done  = 1'b1;
				state_d.state = ST_IDLE;
			end
			default: begin
				state_d.state = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			state_q          <= '0;
			state_q.state    <= ST_IDLE;
			state_q.interval <= INTERVAL_SEL_RESET;
		end else begin
			state_q <= state_d;
		end
	end

	assign supervisorEnableOut  = state_q.enableOut;
	assign sourceClockSelect    = state_q.source;
	assign intervalSelectOut    = state_q.interval;
	assign configWrite          = state_q.write;
	assign timebaseClearInhibit = state_q.inhibit;
	assign busy                 = state_q.busy;
	assign done                 = state_q.done;
	assign verdict              = state_q.verdict;
	assign countOut             = state_q.count;
	assign requestRefused       = state_q.refused;
endmodule // supervisor_host

// File: test/supervisor_host_asserts.sv
// Port checker for the supervisor host controller.
`timescale 1ns/1ps
module supervisor_host_asserts (
	input wire logic       core_clk,
	input wire logic       rst_n,
	input wire logic       startReq,
	input wire logic [2:0] intervalSel,
	input wire logic [1:0] gearDiv,
	input wire logic       crModeActive,
	input wire logic       watchdogStandby,
	input wire logic [7:0] expectLow,
	input wire logic [7:0] expectHigh,
	input wire logic       supervisorEnableOut,
	input wire logic       configWrite,
	input wire logic       timebaseClearInhibit,
	input wire logic       busy,
	input wire logic       done,
	input wire logic [1:0] verdict,
	input wire logic [7:0] countOut,
	input wire logic       requestRefused
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	wire take = startReq && !busy;
	chk_bad_pair:
		assert property (take && (gearDiv != 0 && intervalSel == 0 || gearDiv == 3
			&& intervalSel == 1) |=> requestRefused && !busy) else $error("pair taken");
	chk_bad_mode:
		assert property (take && !(crModeActive && watchdogStandby) |=> requestRefused && !busy)
			else $error("mode taken");
	chk_write_pulse:
		assert property (configWrite |-> supervisorEnableOut ##1 !configWrite) else $error("write");
	chk_inhibit_set:
		assert property (configWrite |=> timebaseClearInhibit) else $error("no inhibit");
	chk_inhibit_busy:
		assert property (timebaseClearInhibit |-> busy) else $error("inhibit idle");
	chk_wait_first:
		assert property ($rose(busy) |-> !configWrite [*8]) else $error("early write");
	chk_normal_range:
		assert property (done && verdict == 2'h1 |-> countOut >= expectLow && countOut <= expectHigh
			&& countOut != 8'h00 && countOut != 8'hFF) else $error("bad normal");
	chk_done_pulse:
		assert property (done |-> !busy ##1 !done) else $error("done shape");
endmodule // supervisor_host_asserts

bind supervisor_host supervisor_host_asserts chk (
	.core_clk             (core_clk),
	.rst_n                (rst_n),
	.startReq             (startReq),
	.intervalSel          (intervalSel),
	.gearDiv              (gearDiv),
	.crModeActive         (crModeActive),
	.watchdogStandby      (watchdogStandby),
	.expectLow            (expectLow),
	.expectHigh           (expectHigh),
	.supervisorEnableOut  (supervisorEnableOut),
	.configWrite          (configWrite),
	.timebaseClearInhibit (timebaseClearInhibit),
	.busy                 (busy),
	.done                 (done),
	.verdict              (verdict),
	.countOut             (countOut),
	.requestRefused       (requestRefused)
);

// File: test/supervised_device.sv
// Behavioural model of the supervised device.
`timescale 1ns/1ps
module supervised_device (
	input  wire logic       oscClk,
	input  wire logic       mainStable,
	input  wire logic       subStable,
	input  var  int         crPs,
	input  wire logic       tbRun,
	input  wire logic       configWrite,
	input  wire logic       supervisorEnableOut,
	input  wire logic [2:0] intervalSelectOut,
	output logic            mainOscStableFlag,
	output logic            subOscStableFlag,
	output logic            supervisorEnableIn,
	output logic [7:0]      measuredCountResult
);
	real     w;
	real     elapsed;
	realtime lastEdge = 0.0;
	int      cnt;
	assign mainOscStableFlag = mainStable;
	assign subOscStableFlag  = subStable;
	// The time of the last oscillator edge tells whether the clock has stopped.
	always @(posedge oscClk) lastEdge = $realtime;
	initial begin
		supervisorEnableIn = 1'h0;
		measuredCountResult = 8'h00;
		forever begin
			@(posedge configWrite);
			// The enable output leaves the same edge; let it settle before reading it.
			#1;
			if (supervisorEnableOut) begin
				supervisorEnableIn = 1'h1;
				measuredCountResult = 8'h00;
				w = (crPs << (2 * intervalSelectOut + 3)) / 1000.0;
				cnt = 0;
				elapsed = 0.0;
				fork
					forever @(posedge oscClk) if (cnt < 255 && tbRun) cnt++;
					while (elapsed < w) begin
						#1;
						if (tbRun) elapsed += 1.0;
					end
				join_any
				disable fork;
				// The enable drops on the falling edge half a window later.
				#(w / 2.0);
				if ($realtime - lastEdge > 200.0) @(posedge oscClk);
				supervisorEnableIn = 1'h0;
				measuredCountResult = cnt[7:0];
				cnt = 0;
			end
		end
	end
endmodule // supervised_device

// File: test/tb.sv
// Self-checking bench: supervisor host against the device model.
`timescale 1ns/1ps
module tb;
	import supervisor_host_pkg::*;
	logic       core_clk = 0, rst_n = 0, startReq = 0, sourceSub = 0, oscClk = 0;
	logic       crModeActive = 1, watchdogStandby = 1, mainStable = 1, subStable = 1;
	logic       oscRun = 1, tbRun = 1;
	logic [2:0] intervalSel = 0, intervalSelectOut;
	logic [1:0] gearDiv = 0, verdict;
	logic [7:0] expectLow = 0, expectHigh = 0, measuredCountResult, countOut;
	logic       mainOscStableFlag, subOscStableFlag, supervisorEnableIn, supervisorEnableOut;
	logic       sourceClockSelect, configWrite, timebaseClearInhibit, busy, done, requestRefused;
	int         crPs = 0, miscompares = 0, compares = 0;
	supervisor_host #(.WAIT_CYCLES(16), .POLL_LIMIT(20000)) uut (
		.core_clk             (core_clk),
		.rst_n                (rst_n),
		.startReq             (startReq),
		.sourceSub            (sourceSub),
		.intervalSel          (intervalSel),
		.gearDiv              (gearDiv),
		.crModeActive         (crModeActive),
		.watchdogStandby      (watchdogStandby),
		.expectLow            (expectLow),
		.expectHigh           (expectHigh),
		.mainOscStableFlag    (mainOscStableFlag),
		.subOscStableFlag     (subOscStableFlag),
		.supervisorEnableIn   (supervisorEnableIn),
		.measuredCountResult  (measuredCountResult),
		.supervisorEnableOut  (supervisorEnableOut),
		.sourceClockSelect    (sourceClockSelect),
		.intervalSelectOut    (intervalSelectOut),
		.configWrite          (configWrite),
		.timebaseClearInhibit (timebaseClearInhibit),
		.busy                 (busy),
		.done                 (done),
		.verdict              (verdict),
		.countOut             (countOut),
		.requestRefused       (requestRefused)
	);
	supervised_device dev (
		.oscClk              (oscClk),
		.mainStable          (mainStable),
		.subStable           (subStable),
		.crPs                (crPs),
		.tbRun               (tbRun),
		.configWrite         (configWrite),
		.supervisorEnableOut (supervisorEnableOut),
		.intervalSelectOut   (intervalSelectOut),
		.mainOscStableFlag   (mainOscStableFlag),
		.subOscStableFlag    (subOscStableFlag),
		.supervisorEnableIn  (supervisorEnableIn),
		.measuredCountResult (measuredCountResult)
	);
	initial forever #2.5 core_clk = ~core_clk;
	// A stopped oscillator rests low.
	initial forever #80 oscClk = oscRun & ~oscClk;
	task automatic chk(string n, logic [7:0] e, logic [7:0] s);
		compares++;
		if (s !== e) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic run(logic [1:0] g, logic [2:0] i, logic s, logic [1:0] ok, int t, int d);
		logic       bad;
		logic [1:0] ev;
		int         n, cp, w;
		bad = (g != 0 && i == 0) || (g == 3 && i == 1) || ok != 3;
		cp = (t * 1000) >> (2 * i + 3);
		w = (cp << (2 * i + 3)) / 1000;
		@(posedge core_clk);
		gearDiv <= g;
		intervalSel <= i;
		sourceSub <= s;
		crModeActive <= ok[1];
		watchdogStandby <= ok[0];
		crPs <= cp;
		expectLow <= 8'(w / 160 + d - 1);
		expectHigh <= 8'(w / 160 + d + 1);
		startReq <= 1;
		@(posedge core_clk);
		startReq <= 0;
		@(posedge core_clk);
		#1;
		chk("refused", bad, requestRefused);
		if (bad) return;
		n = 0;
		while (done !== 1'h1 && n < 30000) begin
			@(posedge core_clk);
			#1;
			n++;
		end
		chk("done", 1'h1, done);
		// A stopped oscillator keeps the enable high, so the poll runs out.
		ev = !(s ? subStable : mainStable) || !oscRun ? RES_DEAD : (measuredCountResult inside {0, 255}
			|| measuredCountResult < expectLow || measuredCountResult > expectHigh)
			? RES_ABNORMAL : RES_NORMAL;
		chk("verdict", ev, verdict);
		chk("source", s, sourceClockSelect);
		chk("interval", i, intervalSelectOut);
		chk("busy", 8'h00, busy);
		if (ev != RES_DEAD) chk("count", measuredCountResult, countOut);
	endtask
	task automatic end_sim;
		$display("compares=%0d miscompares=%0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	initial begin
		void'($urandom(98));
		repeat (4) @(posedge core_clk);
		rst_n <= 1;
		for (int k = 0; k < 32; k++) begin
			run(k[4:3], k[2:0], k[0], 3, 400 + $urandom % 1600, 0);
		end
		run(0, 3, 0, 2, 800, 0);
		run(0, 3, 0, 1, 800, 0);
		run(0, 4, 0, 3, 45000, 0);
		run(0, 5, 1, 3, 900, 6);
		oscRun <= 0;
		run(0, 3, 0, 3, 800, 0);
		oscRun <= 1;
		fork
			run(0, 3, 0, 3, 800, 0);
			begin
				repeat (30) @(posedge core_clk);
				tbRun <= 0;
				repeat (100) @(posedge core_clk);
				tbRun <= 1;
			end
		join
		mainStable <= 0;
		run(0, 2, 0, 3, 800, 0);
		run(0, 2, 1, 3, 800, 0);
		end_sim;
	end
	// The runs take about 250 us, the poll timeout alone 100 us of it.
	initial begin
		#450000;
		miscompares++;
		end_sim;
	end
endmodule // tb
